// ---- logic/srch_consts.vh ----
`ifndef SRCH_CONSTS_VH
`define SRCH_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SRCH_OFF_DATA 4'h0
`define SRCH_OFF_ERROR 4'h1
`define SRCH_OFF_COUNT 4'h2
`define SRCH_OFF_SECTOR 4'h3
`define SRCH_OFF_CYLLO 4'h4
`define SRCH_OFF_CYLHI 4'h5
`define SRCH_OFF_DEVHEAD 4'h6
`define SRCH_OFF_CMDSTAT 4'h7
`define SRCH_OFF_IRQSTAT 4'h8
`define SRCH_OFF_IRQMASK 4'h9
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SRCH_OP_BUFREAD 8'he4
`define SRCH_OP_DMAREAD 7'h64
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SRCH_DH_LBA 6
`define SRCH_ST_BSY 7
`define SRCH_ST_RDY 6
`define SRCH_ST_DSC 4
`define SRCH_ST_DRQ 3
`define SRCH_ST_ERR 0
`define SRCH_ER_CRC 7
`define SRCH_ER_UNCORRECTABLE_DATA 6
`define SRCH_ER_ADDRESS_NOT_FOUND 4
`define SRCH_ER_COMMAND_ABORTED 2
// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define SRCH_WORDS_PER_SECTOR 9'h100
`define SRCH_RST_STATUS 8'h50
`define SRCH_IRQ_CMDDONE 0
`define SRCH_IRQ_ERROR 1
`endif

// ---- logic/srch_sector_ram.v ----
`timescale 1ns/100ps
// Single-port 256 x 16 sector buffer with registered read
module srch_sector_ram (
    input wire clk,
    input wire wrEn,
    input wire [7:0] addr,
    input wire [15:0] wrData,
    output reg [15:0] rdData
);
    reg [15:0] mem [0:255];

    always @(posedge clk) begin
        if (wrEn) begin
            mem[addr] <= wrData;
        end
        rdData <= mem[addr];
    end
endmodule

// ---- logic/srch_sector_read_handler.v ----
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "srch_consts.vh"
module srch_sector_read_handler (
    input wire clk,
    input wire rst_b,
    input wire [3:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [15:0] regRdData,
    output wire dmaRequest,
    input wire dmaAck_b,
    output reg [15:0] dmaData,
    output reg mediaReq,
    output reg [27:0] mediaAddr,
    output reg mediaLba,
    input wire mediaWordValid,
    input wire [15:0] mediaWord,
    input wire mediaUncorrectable,
    input wire mediaNotFound,
    input wire mediaCrcError,
    input wire mediaSectorDone,
    input wire bufWrEn,
    input wire [7:0] bufWrAddr,
    input wire [15:0] bufWrData,
    output wire irq
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam IDLE = 3'h0;
    localparam FETCH = 3'h1;
    localparam PRIME = 3'h2;
    localparam SEND = 3'h3;
    localparam DONE = 3'h4;

    reg [2:0] state;
    reg [7:0] countReg;
    reg [7:0] sectorReg;
    reg [7:0] cylLo;
    reg [7:0] cylHi;
    reg [7:0] devHead;
    reg [7:0] errorReg;
    reg [7:0] statusReg;
    reg [1:0] irqStat;
    reg [1:0] irqMask;
    reg isDma;
    reg [8:0] remaining;
    reg [8:0] wordIdx;
    reg [27:0] curAddr;
    reg [27:0] lastAddr;
    reg anyDone;
    reg ackS1;
    reg ackS2;
    reg ackS3;
    reg [7:0] ramAddr;
    reg ramWr;
    reg [15:0] ramWrData;
    reg [3:0] errCause;
    wire [15:0] ramRdData;
    wire ackPulse;
    wire cmdWr;
    wire [1:0] irqSet;
    wire mediaErr;

    // ----------------------------------------
    // Sector buffer
    // ----------------------------------------
    srch_sector_ram i_srch_sector_ram (
        .clk(clk),
        .wrEn(ramWr),
        .addr(ramAddr),
        .wrData(ramWrData),
        .rdData(ramRdData)
    );

    // Send prefetches the next word: the read port has one cycle latency
    always @* begin
        ramWr = 1'b0;
        ramWrData = bufWrData;
        ramAddr = wordIdx[7:0];
        if (state == FETCH) begin
            ramWr = mediaWordValid;
            ramWrData = mediaWord;
        end else if (state == IDLE) begin
            // A command write points the port at word 0 for the prime step
            ramWr = bufWrEn & ~cmdWr;
            ramAddr = cmdWr ? 8'h00 : bufWrAddr;
        end else if (state == SEND) begin
            ramAddr = wordIdx[7:0] + 8'h01;
        end
    end

    // ----------------------------------------
    // Host acknowledge synchroniser
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            ackS1 <= 1'b1;
            ackS2 <= 1'b1;
            ackS3 <= 1'b1;
        end else begin
            ackS1 <= dmaAck_b;
            ackS2 <= ackS1;
            ackS3 <= ackS2;
        end
    end
    assign ackPulse = ackS3 & ~ackS2;

    assign dmaRequest = (state == SEND) & ~ackPulse;

    assign cmdWr = regWr && regAddr == `SRCH_OFF_CMDSTAT && state == IDLE;
    assign mediaErr = mediaUncorrectable | mediaNotFound | mediaCrcError;

    // ----------------------------------------
    // Command sequencer
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            state <= IDLE;
            countReg <= 8'h00;
            sectorReg <= 8'h00;
            cylLo <= 8'h00;
            cylHi <= 8'h00;
            devHead <= 8'h00;
            errorReg <= 8'h00;
            statusReg <= `SRCH_RST_STATUS;
            isDma <= 1'b0;
            remaining <= 9'h000;
            wordIdx <= 9'h000;
            curAddr <= 28'h0000000;
            lastAddr <= 28'h0000000;
            anyDone <= 1'b0;
            mediaReq <= 1'b0;
            mediaAddr <= 28'h0000000;
            mediaLba <= 1'b0;
            dmaData <= 16'h0000;
            errCause <= 4'h0;
        end else begin
            case (state)
            IDLE: begin
                if (regWr && state == IDLE) begin
                    case (regAddr)
                    `SRCH_OFF_COUNT: countReg <= regWrData;
                    `SRCH_OFF_SECTOR: sectorReg <= regWrData;
                    `SRCH_OFF_CYLLO: cylLo <= regWrData;
                    `SRCH_OFF_CYLHI: cylHi <= regWrData;
                    `SRCH_OFF_DEVHEAD: devHead <= regWrData;
                    default: ;
                    endcase
                end
                if (cmdWr) begin
                    errorReg <= 8'h00;
                    statusReg <= 8'h80;
                    wordIdx <= 9'h000;
                    anyDone <= 1'b0;
                    if (regWrData == `SRCH_OP_BUFREAD) begin
                        isDma <= 1'b0;
                        state <= PRIME;
                    end else if (regWrData[7:1] == `SRCH_OP_DMAREAD) begin
                        isDma <= 1'b1;
                        remaining <= (countReg == 8'h00) ? 9'h100 :
                            {1'b0, countReg};
                        curAddr <= {devHead[3:0], cylHi, cylLo, sectorReg};
                        mediaLba <= devHead[`SRCH_DH_LBA];
                        state <= FETCH;
                    end else begin
                        errorReg[`SRCH_ER_COMMAND_ABORTED] <= 1'b1;
                        isDma <= 1'b0;
                        statusReg <= 8'h51;
                        state <= DONE;
                    end
                end
            end
            FETCH: begin
                mediaReq <= 1'b1;
                mediaAddr <= curAddr;
                if (mediaWordValid) begin
                    wordIdx <= wordIdx + 9'h001;
                end
                if (mediaReq && mediaErr) begin
                    mediaReq <= 1'b0;
                    errCause <= {mediaCrcError, mediaUncorrectable,
                        mediaNotFound, 1'b0};
                    state <= DONE;
                end else if (mediaReq && mediaSectorDone) begin
                    mediaReq <= 1'b0;
                    wordIdx <= 9'h000;
                    state <= PRIME;
                end
            end
            PRIME: begin
                // Buffer read latency: one cycle before the first word
                dmaData <= ramRdData;
                statusReg[`SRCH_ST_DRQ] <= 1'b1;
                state <= SEND;
            end
            SEND: begin
                if (ackPulse) begin
                    dmaData <= ramRdData;
                    wordIdx <= wordIdx + 9'h001;
                    if (wordIdx == `SRCH_WORDS_PER_SECTOR - 9'h001) begin
                        statusReg[`SRCH_ST_DRQ] <= 1'b0;
                        if (!isDma) begin
                            state <= DONE;
                        end else begin
                            remaining <= remaining - 9'h001;
                            lastAddr <= curAddr;
                            anyDone <= 1'b1;
                            curAddr <= curAddr + 28'h0000001;
                            state <= (remaining == 9'h001) ? DONE : FETCH;
                        end
                    end
                end
            end
            DONE: begin
                if (isDma) begin
                    countReg <= remaining[7:0];
                    if (anyDone) begin
                        sectorReg <= lastAddr[7:0];
                        cylLo <= lastAddr[15:8];
                        cylHi <= lastAddr[23:16];
                        devHead[3:0] <= lastAddr[27:24];
                    end
                end
                if (errCause != 4'h0) begin
                    errorReg[`SRCH_ER_CRC] <= errCause[3];
                    errorReg[`SRCH_ER_UNCORRECTABLE_DATA] <= errCause[2];
                    errorReg[`SRCH_ER_ADDRESS_NOT_FOUND] <= errCause[1];
                    statusReg <= 8'h51;
                end else if (!errorReg[`SRCH_ER_COMMAND_ABORTED]) begin
                    statusReg <= `SRCH_RST_STATUS;
                end
                errCause <= 4'h0;
                state <= IDLE;
            end
            default: state <= IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Interrupt status, cleared on read
    // ----------------------------------------
    // One done pulse per command, raised when status is final
    assign irqSet[`SRCH_IRQ_CMDDONE] = (state == DONE);
    assign irqSet[`SRCH_IRQ_ERROR] = (state == DONE) &&
        (errCause != 4'h0 || errorReg[`SRCH_ER_COMMAND_ABORTED]);

    always @(posedge clk) begin
        if (!rst_b) begin
            irqStat <= 2'h0;
            irqMask <= 2'h0;
        end else begin
            // Set wins over the read-clear
            if (regRd && regAddr == `SRCH_OFF_IRQSTAT) begin
                irqStat <= irqSet;
            end else begin
                irqStat <= irqStat | irqSet;
            end
            if (regWr && regAddr == `SRCH_OFF_IRQMASK) begin
                irqMask <= regWrData[1:0];
            end
        end
    end
    assign irq = |(irqStat & irqMask);

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            regRdData <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
            `SRCH_OFF_DATA: regRdData <= dmaData;
            `SRCH_OFF_ERROR: regRdData <= {8'h00, errorReg};
            `SRCH_OFF_COUNT: regRdData <= {8'h00, countReg};
            `SRCH_OFF_SECTOR: regRdData <= {8'h00, sectorReg};
            `SRCH_OFF_CYLLO: regRdData <= {8'h00, cylLo};
            `SRCH_OFF_CYLHI: regRdData <= {8'h00, cylHi};
            `SRCH_OFF_DEVHEAD: regRdData <= {8'h00, devHead};
            `SRCH_OFF_CMDSTAT: regRdData <= {8'h00, statusReg};
            `SRCH_OFF_IRQSTAT: regRdData <= {14'h0, irqStat};
            `SRCH_OFF_IRQMASK: regRdData <= {14'h0, irqMask};
            default: regRdData <= 16'h0000;
            endcase
        end else begin
            regRdData <= 16'h0000;
        end
    end
endmodule

// ---- verif/srch_monitor.sv ----
`timescale 1ns/100ps
module srch_monitor (
    input wire clk,
    input wire rst_b,
    input wire regRd,
    input wire regWr,
    input wire [15:0] regRdData,
    input wire dmaRequest,
    input wire dmaAck_b,
    input wire [15:0] dmaData,
    input wire mediaReq,
    input wire [27:0] mediaAddr,
    input wire mediaLba,
    input wire mediaSectorDone,
    input wire irq
);
    // ----------------
    // Port checks
    // ----------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    rd_idle_zero_a: assert property (
        !$past(regRd) |-> regRdData == 16'h0) else $error("stray read data");
    reset_quiet_a: assert property (
        !$past(rst_b) |-> !irq && !mediaReq && !dmaRequest)
        else $error("outputs busy after reset");
    irq_after_xfer_a: assert property (
        $rose(irq) |-> !dmaRequest && !mediaReq)
        else $error("interrupt during transfer");
    irq_clear_cause_a: assert property (
        $fell(irq) |-> $past(regRd) || $past(regWr))
        else $error("interrupt dropped by itself");
    ack_drops_req_a: assert property (
        $fell(dmaAck_b) && dmaRequest |-> ##[1:5] !dmaRequest)
        else $error("request held after ack");
    data_hold_a: assert property (
        $past(dmaRequest) && dmaRequest |-> $stable(dmaData))
        else $error("word changed without ack");
    addr_hold_a: assert property (
        $past(mediaReq) && mediaReq && !$past(mediaSectorDone)
        |-> $stable(mediaAddr) && $stable(mediaLba))
        else $error("media address moved mid sector");
    fetch_excl_a: assert property (
        mediaReq |-> !dmaRequest) else $error("fetch and send overlap");
endmodule
bind srch_sector_read_handler srch_monitor i_srch_monitor (.clk, .rst_b,
    .regRd, .regWr, .regRdData, .dmaRequest, .dmaAck_b, .dmaData,
    .mediaReq, .mediaAddr, .mediaLba, .mediaSectorDone, .irq);

// ---- verif/srch_host_model.sv ----
`timescale 1ns/100ps
module srch_host_model (
    input wire clk,
    input wire slow,
    input wire restart,
    input wire dmaRequest,
    input wire [15:0] dmaData,
    output reg dmaAck_b = 1'b1,
    input wire mediaReq,
    input wire [8:0] failSector,
    output reg mediaWordValid = 1'b0,
    output reg [15:0] mediaWord = 16'h0,
    output reg mediaUncorrectable = 1'b0,
    output reg mediaSectorDone = 1'b0
);
    // ----------------
    // Host DMA channel and media
    // ----------------
    reg [15:0] got [0:255];
    reg [15:0] words = 16'h0;
    reg [8:0] sectors = 9'h0;
    reg [8:0] wcnt = 9'h0;
    reg [3:0] gap = 4'h0;
    wire fetching = mediaReq && !mediaSectorDone && !restart;
    wire failing = fetching && sectors == failSector;
    wire lastWord = fetching && !failing && wcnt == 9'h100;
    // Gap covers the ack synchroniser, so a word is never taken twice
    always @(posedge clk) begin
        if (restart) begin
            words <= 16'h0;
            gap <= 4'h0;
            dmaAck_b <= 1'b1;
        end else if (gap != 4'h0) begin
            gap <= gap - 4'h1;
            dmaAck_b <= 1'b1;
        end else if (dmaRequest) begin
            got[words[7:0]] <= dmaData;
            words <= words + 16'h1;
            dmaAck_b <= 1'b0;
            gap <= slow ? 4'hc : 4'h6;
        end else begin
            dmaAck_b <= 1'b1;
        end
    end
    // Data pattern toggles each cycle, so word order shows at the host
    always @(posedge clk) begin
        mediaWord <= ~mediaWord;
        mediaUncorrectable <= failing;
        mediaSectorDone <= lastWord;
        mediaWordValid <= fetching && !failing && !lastWord;
        if (!fetching)
            wcnt <= 9'h0;
        else if (!failing && !lastWord)
            wcnt <= wcnt + 9'h1;
        if (restart)
            sectors <= 9'h0;
        else if (lastWord)
            sectors <= sectors + 9'h1;
    end
endmodule

// ---- verif/test_srch_sector_read_handler.sv ----
`timescale 1ns/100ps
module test_srch_sector_read_handler;
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg [3:0] regAddr = 4'h0;
    reg [7:0] regWrData = 8'h00;
    reg regWr = 1'b0;
    reg regRd = 1'b0;
    reg bufWrEn = 1'b0;
    reg [7:0] bufWrAddr = 8'h00;
    reg [15:0] bufWrData = 16'h0000;
    reg mediaNotFound = 1'b0;
    reg mediaCrcError = 1'b0;
    reg [8:0] failSector = 9'h1ff;
    reg slow = 1'b0;
    reg restart = 1'b0;
    wire [15:0] regRdData, dmaData, mediaWord;
    wire dmaRequest, dmaAck_b, mediaReq, mediaLba, irq;
    wire mediaWordValid, mediaUncorrectable, mediaSectorDone;
    wire [27:0] mediaAddr;
    integer err_total = 0, samples_checked = 0, cycles = 0, i;
    reg [15:0] fetches = 16'h0, rdv;
    reg [27:0] startAddr;
    reg startLba, reqQ = 1'b0;
    srch_sector_read_handler i_srch_sector_read_handler (.clk, .rst_b,
        .regAddr, .regWrData, .regWr, .regRd, .regRdData, .dmaRequest,
        .dmaAck_b, .dmaData, .mediaReq, .mediaAddr, .mediaLba,
        .mediaWordValid, .mediaWord, .mediaUncorrectable, .mediaNotFound,
        .mediaCrcError, .mediaSectorDone, .bufWrEn, .bufWrAddr,
        .bufWrData, .irq);
    srch_host_model i_srch_host_model (.clk, .slow, .restart, .dmaRequest,
        .dmaData, .dmaAck_b, .mediaReq, .failSector, .mediaWordValid,
        .mediaWord, .mediaUncorrectable, .mediaSectorDone);
    always #50 clk = ~clk;
    // ----------------
    // Helpers
    // ----------------
    always @(posedge clk) begin
        reqQ <= mediaReq;
        cycles = cycles + 1;
        if (restart) begin
            fetches <= 16'h0;
        end else if (mediaReq && !reqQ) begin
            if (fetches == 16'h0) begin
                startAddr <= mediaAddr;
                startLba <= mediaLba;
            end
            fetches <= fetches + 16'h1;
        end
        if (cycles == 40000) begin
            err_total = err_total + 1;
            end_of_test;
        end
    end
    task end_of_test;
        begin
            $display("Errors %0d, checks %0d", err_total, samples_checked);
            if (err_total == 0 && samples_checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task chk(input [15:0] g, input [15:0] e);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("Error at %0t: got %h want %h", $time, g, e);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk);
            regWr <= 1'b1;
            regAddr <= a;
            regWrData <= d;
            @(posedge clk);
            regWr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge clk);
            regRd <= 1'b1;
            regAddr <= a;
            @(posedge clk);
            regRd <= 1'b0;
            #1 rdv = regRdData;
        end
    endtask
    task run(input [7:0] op);
        begin
            @(posedge clk);
            restart <= 1'b1;
            @(posedge clk);
            restart <= 1'b0;
            wr(4'h7, op);
            i = 0;
            while (irq !== 1'b1 && i < 20000) begin
                @(posedge clk);
                i = i + 1;
            end
            #1 chk({15'h0, irq}, 16'h1);
        end
    endtask
    // ----------------
    // Scenarios
    // ----------------
    task t_bufread;
        begin
            for (i = 0; i < 256; i = i + 1) begin
                @(posedge clk);
                bufWrEn <= 1'b1;
                bufWrAddr <= i[7:0];
                bufWrData <= 16'h5a00 ^ i[15:0];
            end
            @(posedge clk);
            bufWrEn <= 1'b0;
            run(8'he4);
            chk(i_srch_host_model.words, 16'h100);
            chk(fetches, 16'h0);
            for (i = 0; i < 256; i = i + 1)
                chk(i_srch_host_model.got[i], 16'h5a00 ^ i[15:0]);
            rd(4'h8);
            chk(rdv, 16'h1);
        end
    endtask
    task t_dma(input [7:0] op);
        begin
            wr(4'h2, 8'h02);
            wr(4'h3, 8'hef);
            wr(4'h4, 8'hcd);
            wr(4'h5, 8'hab);
            wr(4'h6, 8'he5);
            run(op);
            chk(i_srch_host_model.words, 16'h200);
            chk(fetches, 16'h2);
            chk(i_srch_host_model.got[0] ^ i_srch_host_model.got[1],
                16'hffff);
            chk(startAddr[15:0], 16'hcdef);
            chk({4'h0, startAddr[27:16]}, 16'h05ab);
            rd(4'h2);
            chk(rdv, 16'h0);
            rd(4'h3);
            chk(rdv, 16'h00f0);
            rd(4'h4);
            chk(rdv, 16'h00cd);
            rd(4'h6);
            chk(rdv & 16'h000f, 16'h0005);
            rd(4'h7);
            chk(rdv, 16'h0050);
            rd(4'h8);
            chk({15'h0, irq}, 16'h0);
        end
    endtask
    task t_err;
        begin
            @(posedge clk);
            failSector <= 9'h002;
            slow <= 1'b1;
            wr(4'h2, 8'h00);
            wr(4'h6, 8'ha0);
            run(8'hc8);
            chk(i_srch_host_model.words, 16'h200);
            chk({15'h0, startLba}, 16'h0);
            rd(4'h2);
            chk(rdv, 16'h00fe);
            rd(4'h7);
            chk(rdv, 16'h0051);
            rd(4'h1);
            chk(rdv & 16'h0040, 16'h0040);
            rd(4'h8);
            chk(rdv & 16'h0002, 16'h0002);
            @(posedge clk);
            failSector <= 9'h1ff;
            slow <= 1'b0;
        end
    endtask
    task t_abort;
        begin
            wr(4'h9, 8'h00);
            wr(4'h7, 8'h00);
            repeat (20) @(posedge clk);
            #1 chk({15'h0, irq}, 16'h0);
            rd(4'h1);
            chk(rdv & 16'h0004, 16'h0004);
            wr(4'h9, 8'h03);
            #1 chk({15'h0, irq}, 16'h1);
            rd(4'h8);
            chk({15'h0, irq}, 16'h0);
            rd(4'hf);
            chk(rdv, 16'h0);
        end
    endtask
    task t_flags;
        begin
            wr(4'h2, 8'h01);
            @(posedge clk);
            mediaNotFound <= 1'b1;
            mediaCrcError <= 1'b1;
            run(8'hc9);
            chk(i_srch_host_model.words, 16'h0);
            rd(4'h1);
            chk(rdv, 16'h0090);
            rd(4'h2);
            chk(rdv, 16'h0001);
            rd(4'h8);
            chk(rdv, 16'h0003);
            @(posedge clk);
            mediaNotFound <= 1'b0;
            mediaCrcError <= 1'b0;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(4'h7);
        chk(rdv, 16'h0050);
        wr(4'h9, 8'h03);
        t_bufread;
        t_dma(8'hc8);
        t_dma(8'hc9);
        t_err;
        t_flags;
        t_abort;
        end_of_test;
    end
endmodule
